// ===== touch_sense_defines.svh
// constants for the touch-sense global configuration bank
// assumes inclusion by bare name from the package and design modules
`ifndef TOUCH_SENSE_DEFINES_SVH
`define TOUCH_SENSE_DEFINES_SVH
// register offsets on the serial port
`define REG_SENS        8'h1F
`define REG_CFG         8'h20
`define REG_CFG2        8'h44
`define BUS_UNMAPPED    8'h00
// reset values and writable masks
`define SENS_RESET      8'h20
`define CFG_RESET_REV_B 8'hA0
`define CFG_RESET_REV_C 8'h20
`define CFG2_RESET      8'h40
`define SENS_MASK       8'h7F
`define CFG_MASK        8'hB8
`define CFG2_MASK       8'hFD
// field positions
`define GAIN_MSB        6
`define GAIN_LSB        4
`define BSHIFT_MSB      3
`define BSHIFT_LSB      0
`define CFG_TIMEOUT_BIT 7
`define CFG_DIGNS_BIT   5
`define CFG_LFNS_BIT    4
`define CFG_HOLD_BIT    3
// delta and base presentation
`define DELTA_POS_MAX   8'h7F
`define DELTA_NEG_MAX   8'h80
`define DELTA_ZERO      8'h00
`define BSHIFT_LIMIT    4'h8
`define BASE_MAX        8'hFF
`define GAIN_DEFAULT    3'h2
// serial byte framing
`define BYTE_BITS       4'h8
`define LAST_TX_BIT     4'h7
// timing
`define CLK_KHZ         100000
`define CLK_MHZ         100
`define SCL_LOW_MS      30
`define BUS_IDLE_US     200
`define TICK_MS         1
// hold limit decode in milliseconds
`define HOLD_MS_0  14'd560
`define HOLD_MS_1  14'd840
`define HOLD_MS_2  14'd1120
`define HOLD_MS_3  14'd1400
`define HOLD_MS_4  14'd1680
`define HOLD_MS_5  14'd2240
`define HOLD_MS_6  14'd2800
`define HOLD_MS_7  14'd3360
`define HOLD_MS_8  14'd3920
`define HOLD_MS_9  14'd4480
`define HOLD_MS_A  14'd5600
`define HOLD_MS_B  14'd6720
`define HOLD_MS_C  14'd7840
`define HOLD_MS_D  14'd8906
`define HOLD_MS_E  14'd10080
`define HOLD_MS_F  14'd11200
`endif

// ===== touch_sense_pkg.sv
// types and shared decode for the touch-sense configuration bank
// assumes the defines header is on the include path
`include "touch_sense_defines.svh"
package touch_sense_pkg;
	// serial port states, gray along address, pointer, write, read
	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_ADDR     = 4'h1,
		ST_ADDR_ACK = 4'h3,
		ST_PTR      = 4'h2,
		ST_PTR_ACK  = 4'h6,
		ST_WR       = 4'h7,
		ST_WR_ACK   = 4'h5,
		ST_RD       = 4'h4,
		ST_RD_ACK   = 4'hC
	} bus_state_t;

	// hold limit code to milliseconds
	function automatic logic [13:0] holdLimitMs(input logic [3:0] code);
		case (code)
			4'h0: holdLimitMs = `HOLD_MS_0;
			4'h1: holdLimitMs = `HOLD_MS_1;
			4'h2: holdLimitMs = `HOLD_MS_2;
			4'h3: holdLimitMs = `HOLD_MS_3;
			4'h4: holdLimitMs = `HOLD_MS_4;
			4'h5: holdLimitMs = `HOLD_MS_5;
			4'h6: holdLimitMs = `HOLD_MS_6;
			4'h7: holdLimitMs = `HOLD_MS_7;
			4'h8: holdLimitMs = `HOLD_MS_8;
			4'h9: holdLimitMs = `HOLD_MS_9;
			4'hA: holdLimitMs = `HOLD_MS_A;
			4'hB: holdLimitMs = `HOLD_MS_B;
			4'hC: holdLimitMs = `HOLD_MS_C;
			4'hD: holdLimitMs = `HOLD_MS_D;
			4'hE: holdLimitMs = `HOLD_MS_E;
			default: holdLimitMs = `HOLD_MS_F;
		endcase
	endfunction
endpackage

// ===== touch_channel.sv
// one sensor channel: gain scaling, noise gating, hold recalibration
// assumes raw counts and strobes come from same-clock sensing logic
`timescale 1ns/1ps
`include "touch_sense_defines.svh"
module touch_channel
	import touch_sense_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               reset_n,
	input  wire logic [2:0]         gainCode,
	input  wire logic [3:0]         baseShift,
	input  wire logic               noiseGateOff,
	input  wire logic               lfFilterOff,
	input  wire logic               holdEnable,
	input  wire logic [3:0]         holdLimitCode,
	input  wire logic               msTick,
	input  wire logic               sampleValid,
	input  wire logic signed [15:0] rawDelta,
	input  wire logic [15:0]        rawBase,
	input  wire logic               lowFreqNoise,
	input  wire logic [7:0]         noiseThreshold,
	input  wire logic [7:0]         touchThreshold,
	output logic [7:0]              deltaCount,
	output logic [7:0]              baseShown,
	output logic                    touched,
	output logic                    recalUse,
	output logic                    recalRestart
);
	logic signed [15:0] scaled;    // delta after gain shift
	logic [7:0]         deltaNext; // presented delta
	logic               blocked;   // low-frequency noise block
	logic               touchNext; // delta above touch threshold
	logic               discard;   // sample kept out of recal
	logic [15:0]        baseWide;  // base after readout shift
	logic [13:0]        holdMs;    // milliseconds touched

	// clamp to eight-bit two's complement
	function automatic logic [7:0] sat8(input logic signed [15:0] v);
		if (v > $signed({8'h00, `DELTA_POS_MAX}))
			sat8 = `DELTA_POS_MAX;
		else if (v < $signed({8'hFF, `DELTA_NEG_MAX}))
			sat8 = `DELTA_NEG_MAX;
		else
			sat8 = v[7:0];
	endfunction

	// gain: each code step halves the multiplier
	always_comb begin
		scaled    = rawDelta >>> gainCode;
		blocked   = lowFreqNoise && !lfFilterOff;
		deltaNext = blocked ? `DELTA_ZERO : sat8(scaled);
		touchNext = $signed({deltaNext[7], deltaNext}) >
			$signed({1'b0, touchThreshold});
		// in-band noise is only gated while the gate is on
		discard   = blocked || (!noiseGateOff && !touchNext &&
			($signed({deltaNext[7], deltaNext}) >
			$signed({1'b0, noiseThreshold})));
		// codes above the top scale clamp to it
		baseWide  = rawBase >> ((baseShift > `BSHIFT_LIMIT) ?
			`BSHIFT_LIMIT : baseShift);
	end

	// delta and touch update once per sensing strobe; recalUse pulses for that one cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			deltaCount <= `DELTA_ZERO;
			touched    <= 1'b0;
			recalUse   <= 1'b0;
		end else begin
			recalUse <= sampleValid && !touchNext && !discard;
			if (sampleValid) begin
				deltaCount <= deltaNext;
				touched    <= touchNext;
			end
		end
	end

	// base readout: presentation only, never feeds detection
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			baseShown <= `DELTA_ZERO;
		else if (sampleValid)
			baseShown <= (|baseWide[15:8]) ? `BASE_MAX : baseWide[7:0];
	end

	// hold timer: counts milliseconds of continuous touch
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			holdMs       <= 14'h0000;
			recalRestart <= 1'b0;
		end else begin
			recalRestart <= 1'b0;
			if (!touched || !holdEnable)
				holdMs <= 14'h0000;
			else if (msTick) begin
				if (holdMs >= holdLimitMs(holdLimitCode)) begin
					recalRestart <= 1'b1;
					holdMs       <= 14'h0000;
				end else
					holdMs <= holdMs + 14'h0001;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	AST_LF_BLOCK: assert property (
		sampleValid && lowFreqNoise && !lfFilterOff
		|=> deltaCount == `DELTA_ZERO)
		else $error("delta not zeroed under low-frequency noise");
	AST_SAT_POS: assert property (
		sampleValid && !blocked && scaled > $signed({8'h00, `DELTA_POS_MAX})
		|=> deltaCount == `DELTA_POS_MAX)
		else $error("positive delta not saturated");
	AST_GAIN_TOP: assert property (
		sampleValid && !blocked && gainCode == 3'h0 && rawDelta == 16'sh0040
		|=> deltaCount == 8'h40)
		else $error("top gain weight wrong");
	AST_GATE_DISCARD: assert property (
		sampleValid && !noiseGateOff && !touchNext && !blocked &&
		$signed({deltaNext[7], deltaNext}) > $signed({1'b0, noiseThreshold})
		|=> !recalUse)
		else $error("in-band noise sample reached recal");
	AST_HOLD_OFF: assert property (
		!holdEnable ##1 !holdEnable |-> !recalRestart)
		else $error("restart while hold recal disabled");
	COV_RESTART: cover property (recalRestart);
	COV_SAT_NEG: cover property (sampleValid ##1 deltaCount == `DELTA_NEG_MAX);
endmodule

// ===== touch_sense_config.sv
// global configuration bank with its serial register port
// assumes: serial pins are asynchronous, sensing strobes share sys_clk
// Function
// - gain code halves multiplier, 32x default
// - scale each delta by selected gain
// - top bit weighs 64 to 8192 counts
// - base scale shifts presentation 1x to 256x
// - base scale affects presentation only
// - timeout abandons transfer after 30ms low clock
// - timeout resets port after 200us idle high
// - timeout off disables both bus timers
// - timeout bit resets per functional revision
// - noise gate drops in-band samples from recal
// - gate off: sub-threshold deltas feed recal
// - filter on zeroes delta under low-frequency noise
// - filter off never blocks for noise
// - hold recal off: no recal on touch
// - hold recal on: restart after hold limit
// - hold limit decodes 560ms to 11200ms
// - delta saturates at 7Fh and 80h
`timescale 1ns/1ps
`include "touch_sense_defines.svh"
module touch_sense_config
	import touch_sense_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR    = 7'h28, // arbitrary default
	parameter bit         REV_B         = 1'b0,  // reset flavour
	parameter int unsigned LOW_CYCLES   = `SCL_LOW_MS * `CLK_KHZ,
	parameter int unsigned IDLE_CYCLES  = `BUS_IDLE_US * `CLK_MHZ,
	parameter int unsigned MS_CYCLES    = `TICK_MS * `CLK_KHZ
)
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	input  wire logic [2:0]  sampleValid,
	input  wire logic [47:0] rawDelta,
	input  wire logic [47:0] rawBase,
	input  wire logic [2:0]  lowFreqNoise,
	input  wire logic [23:0] noiseThreshold,
	input  wire logic [23:0] touchThreshold,
	input  wire logic [3:0]  holdLimitCode,
	output logic [23:0]      deltaCount,
	output logic [23:0]      baseShown,
	output logic [2:0]       touched,
	output logic [2:0]       recalUse,
	output logic [2:0]       recalRestart,
	output logic             linkedTransitionInvert,
	output logic             alertPinPolarity,
	output logic             sensorPowerdownBlock,
	output logic             polarityMirrorUnlink,
	output logic             radioNoiseOnlyFlags,
	output logic             radioNoiseFilterOff,
	output logic             releaseIrqSuppress
);
	localparam logic [7:0] CFG_RESET =
		REV_B ? `CFG_RESET_REV_B : `CFG_RESET_REV_C;

	logic [7:0]  sensReg;   // gain and base scale
	logic [7:0]  cfgReg;    // global configuration
	logic [7:0]  cfg2Reg;   // second configuration
	logic [1:0]  sclSync;   // clock pin synchroniser
	logic [1:0]  sdaSync;   // data pin synchroniser
	logic        sclLast;   // previous synced clock
	logic        sdaLast;   // previous synced data
	logic        sclRise;   // clock rising edge
	logic        sclFall;   // clock falling edge
	logic        startCond; // start or repeated start
	logic        stopCond;  // stop
	bus_state_t  stateReg;  // port state
	logic [3:0]  bitCnt;    // bits in current byte
	logic [7:0]  shiftReg;  // received byte
	logic [7:0]  txReg;     // byte being sent
	logic [7:0]  ptrReg;    // register pointer
	logic        rwReg;     // read request
	logic        nackReg;   // host refused further reads
	logic [31:0] lowCnt;    // clock held low time
	logic [31:0] idleCnt;   // both lines high time
	logic        lowAbort;  // clock held too long
	logic        idleAbort; // bus idle too long
	logic        byteDone;  // eighth bit taken at fall
	logic        wrStrobe;  // data byte written
	logic [31:0] tickCnt;   // millisecond prescaler
	logic        msTick;    // one-millisecond pulse

	// read decode; unmapped pointers give zero
	function automatic logic [7:0] readReg(input logic [7:0] p,
		input logic [7:0] s, input logic [7:0] c, input logic [7:0] c2);
		case (p)
			`REG_SENS: readReg = s;
			`REG_CFG:  readReg = c;
			`REG_CFG2: readReg = c2;
			default:   readReg = `BUS_UNMAPPED;
		endcase
	endfunction

	// two flops before any logic looks at the pins
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
			sclLast <= 1'b1;
			sdaLast <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], sclIn};
			sdaSync <= {sdaSync[0], sdaIn};
			sclLast <= sclSync[1];
			sdaLast <= sdaSync[1];
		end
	end

	// line events, all from the second synchroniser stage
	always_comb begin
		sclRise   = sclSync[1] && !sclLast;
		sclFall   = !sclSync[1] && sclLast;
		startCond = sclSync[1] && sclLast && !sdaSync[1] && sdaLast;
		stopCond  = sclSync[1] && sclLast && sdaSync[1] && !sdaLast;
		byteDone  = sclFall && (bitCnt == `BYTE_BITS);
		wrStrobe  = byteDone && (stateReg == ST_WR);
	end

	// held-low clock timer, only inside a transfer
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !cfgReg[`CFG_TIMEOUT_BIT] || sclSync[1] ||
			stateReg == ST_IDLE)
			lowCnt <= 32'h0000_0000;
		else if (!lowAbort)
			lowCnt <= lowCnt + 32'h0000_0001;
	end
	assign lowAbort = (lowCnt == LOW_CYCLES) && !sclSync[1];

	// idle-high timer; saturates so the reset fires once
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !cfgReg[`CFG_TIMEOUT_BIT] || !sclSync[1] ||
			!sdaSync[1])
			idleCnt <= 32'h0000_0000;
		else if (idleCnt != IDLE_CYCLES)
			idleCnt <= idleCnt + 32'h0000_0001;
	end
	assign idleAbort = (idleCnt == IDLE_CYCLES - 1) && sclSync[1] &&
		sdaSync[1];

	// serial port sequencing
	always_ff @(posedge sys_clk) begin
		if (!reset_n || lowAbort || idleAbort || stopCond) begin
			stateReg <= ST_IDLE;
			bitCnt   <= 4'h0;
		end else if (startCond) begin
			stateReg <= ST_ADDR;
			bitCnt   <= 4'h0;
		end else begin
			case (stateReg)
				ST_ADDR, ST_PTR, ST_WR: begin
					if (sclRise)
						bitCnt <= bitCnt + 4'h1;
					else if (byteDone) begin
						bitCnt <= 4'h0;
						case (stateReg)
							ST_ADDR: stateReg <= (shiftReg[7:1] == SLAVE_ADDR) ?
								ST_ADDR_ACK : ST_IDLE;
							ST_PTR:  stateReg <= ST_PTR_ACK;
							default: stateReg <= ST_WR_ACK;
						endcase
					end
				end
				ST_ADDR_ACK: begin
					if (sclFall)
						stateReg <= rwReg ? ST_RD : ST_PTR;
				end
				ST_PTR_ACK, ST_WR_ACK: begin
					if (sclFall)
						stateReg <= ST_WR;
				end
				ST_RD: begin
					if (sclFall) begin
						bitCnt <= (bitCnt == `LAST_TX_BIT) ? 4'h0 : bitCnt + 4'h1;
						if (bitCnt == `LAST_TX_BIT)
							stateReg <= ST_RD_ACK;
					end
				end
				ST_RD_ACK: begin
					// a host nack ends the read burst
					if (sclFall)
						stateReg <= nackReg ? ST_IDLE : ST_RD;
				end
				default: stateReg <= ST_IDLE;
			endcase
		end
	end

	// receive shifter and direction / ack capture
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			shiftReg <= 8'h00;
			rwReg    <= 1'b0;
			nackReg  <= 1'b1;
		end else begin
			if (sclRise && (stateReg == ST_ADDR || stateReg == ST_PTR ||
				stateReg == ST_WR))
				shiftReg <= {shiftReg[6:0], sdaSync[1]};
			if (byteDone && stateReg == ST_ADDR)
				rwReg <= shiftReg[0];
			if (sclRise && stateReg == ST_RD_ACK)
				nackReg <= sdaSync[1];
		end
	end

	// pointer and transmit byte; pointer steps after each data byte
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ptrReg <= 8'h00;
			txReg  <= 8'h00;
		end else if (sclFall && ((stateReg == ST_ADDR_ACK && rwReg) ||
			(stateReg == ST_RD_ACK && !nackReg))) begin
			txReg  <= readReg(ptrReg, sensReg, cfgReg, cfg2Reg);
			ptrReg <= ptrReg + 8'h01;
		end else if (sclFall && stateReg == ST_RD)
			txReg <= {txReg[6:0], 1'b0};
		else if (byteDone && stateReg == ST_PTR)
			ptrReg <= shiftReg;
		else if (wrStrobe)
			ptrReg <= ptrReg + 8'h01;
	end

	// open-drain data: only ever pulls low
	assign sdaOut = 1'b0;
	assign sdaOe  = (stateReg == ST_ADDR_ACK) || (stateReg == ST_PTR_ACK) ||
		(stateReg == ST_WR_ACK) || (stateReg == ST_RD && !txReg[7]);

	// register bank; masks keep unused bits at zero
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sensReg <= `SENS_RESET;
			cfgReg  <= CFG_RESET;
			cfg2Reg <= `CFG2_RESET;
		end else if (wrStrobe) begin
			case (ptrReg)
				`REG_SENS: sensReg <= shiftReg & `SENS_MASK;
				`REG_CFG:  cfgReg  <= shiftReg & `CFG_MASK;
				`REG_CFG2: cfg2Reg <= shiftReg & `CFG2_MASK;
				default:   sensReg <= sensReg;
			endcase
		end
	end

	// second-configuration bits go to their owners
	always_comb begin
		linkedTransitionInvert = cfg2Reg[7];
		alertPinPolarity       = cfg2Reg[6];
		sensorPowerdownBlock   = cfg2Reg[5];
		polarityMirrorUnlink   = cfg2Reg[4];
		radioNoiseOnlyFlags    = cfg2Reg[3];
		radioNoiseFilterOff    = cfg2Reg[2];
		releaseIrqSuppress     = cfg2Reg[0];
	end

	// millisecond tick shared by the hold timers
	always_ff @(posedge sys_clk) begin
		if (!reset_n || msTick)
			tickCnt <= 32'h0000_0000;
		else
			tickCnt <= tickCnt + 32'h0000_0001;
	end
	assign msTick = (tickCnt == MS_CYCLES - 1);

	// one channel per sensor input
	for (genvar i = 0; i < 3; i++) begin : gChan
		touch_channel uChan (
			.sys_clk        (sys_clk),
			.reset_n        (reset_n),
			.gainCode       (sensReg[`GAIN_MSB:`GAIN_LSB]),
			.baseShift      (sensReg[`BSHIFT_MSB:`BSHIFT_LSB]),
			.noiseGateOff   (cfgReg[`CFG_DIGNS_BIT]),
			.lfFilterOff    (cfgReg[`CFG_LFNS_BIT]),
			.holdEnable     (cfgReg[`CFG_HOLD_BIT]),
			.holdLimitCode  (holdLimitCode),
			.msTick         (msTick),
			.sampleValid    (sampleValid[i]),
			.rawDelta       (rawDelta[16*i +: 16]),
			.rawBase        (rawBase[16*i +: 16]),
			.lowFreqNoise   (lowFreqNoise[i]),
			.noiseThreshold (noiseThreshold[8*i +: 8]),
			.touchThreshold (touchThreshold[8*i +: 8]),
			.deltaCount     (deltaCount[8*i +: 8]),
			.baseShown      (baseShown[8*i +: 8]),
			.touched        (touched[i]),
			.recalUse       (recalUse[i]),
			.recalRestart   (recalRestart[i])
		);
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	AST_CFG_RESET: assert property (
		$rose(reset_n) |-> cfgReg == CFG_RESET &&
		sensReg[`GAIN_MSB:`GAIN_LSB] == `GAIN_DEFAULT)
		else $error("configuration reset value wrong");
	AST_RESERVED_ZERO: assert property (
		(cfgReg & ~`CFG_MASK) == 8'h00 && (sensReg & ~`SENS_MASK) == 8'h00 &&
		(cfg2Reg & ~`CFG2_MASK) == 8'h00)
		else $error("unused bit reads nonzero");
	AST_LOW_ABORT: assert property (
		lowAbort |=> stateReg == ST_IDLE ##1 stateReg == ST_IDLE || startCond)
		else $error("held-low clock did not abandon transfer");
	AST_IDLE_RESET: assert property (
		cfgReg[`CFG_TIMEOUT_BIT] && stateReg != ST_IDLE && !stopCond &&
		!startCond && sclSync[1] && sdaSync[1] && idleCnt == IDLE_CYCLES - 1
		|=> stateReg == ST_IDLE)
		else $error("idle bus did not reset port");
	AST_NO_TIMERS: assert property (
		!cfgReg[`CFG_TIMEOUT_BIT] ##1 !cfgReg[`CFG_TIMEOUT_BIT]
		|-> !lowAbort && !idleAbort)
		else $error("bus timer active with timeout off");
	COV_WRITE: cover property (wrStrobe && ptrReg == `REG_CFG);
	COV_READ: cover property (stateReg == ST_RD ##[1:200] stateReg == ST_RD_ACK);
	COV_TIMEOUT: cover property (lowAbort);
endmodule

// ===== touch_host_model.sv
// serial bus master model that talks to the register port
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
module touch_host_model #(
	parameter logic [6:0] ADDR = 7'h2C // device address to call
)(
	input  wire logic sys_clk,
	input  wire logic sdaLine,
	output logic      scl,
	output logic      sdaLow
);
	// idle bus: both lines released
	initial begin
		scl    = 1'b1;
		sdaLow = 1'b0;
	end

	// every pin change lands just after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// data moves two cycles after the clock fall, so no false start
	task automatic sendBit(input logic b);
		tick(2);
		sdaLow = !b;
		tick(6);
		scl = 1'b1;
		tick(8);
		scl = 1'b0;
	endtask

	// release data, let the device decide, sample mid-high
	task automatic recvBit(output logic b);
		tick(2);
		sdaLow = 1'b0;
		tick(6);
		scl = 1'b1;
		tick(4);
		b = sdaLine;
		tick(4);
		scl = 1'b0;
	endtask

	// a one bit whose high phase lasts n cycles, lines both released
	task automatic pause(input int n);
		tick(2);
		sdaLow = 1'b0;
		tick(6);
		scl = 1'b1;
		tick(n);
		scl = 1'b0;
	endtask

	// start, or repeated start when the clock is parked low
	task automatic start();
		if (scl == 1'b0) begin
			tick(2);
			sdaLow = 1'b0;
			tick(6);
			scl = 1'b1;
			tick(8);
		end
		sdaLow = 1'b1;
		tick(8);
		scl = 1'b0;
	endtask

	task automatic stop();
		tick(2);
		sdaLow = 1'b1;
		tick(6);
		scl = 1'b1;
		tick(8);
		sdaLow = 1'b0;
		tick(8);
	endtask

	// msb first, no acknowledge slot
	task automatic sendBits(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			sendBit(d[i]);
		end
	endtask

	task automatic byteOut(input logic [7:0] d, output logic ok);
		logic a;
		sendBits(d);
		recvBit(a);
		ok = !a;
	endtask

	// last byte is answered with a nack to end the read
	task automatic byteIn(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) begin
			recvBit(d[i]);
		end
		sendBit(last);
	endtask

	task automatic writeReg(input logic [7:0] p, d, output logic ok);
		logic a0, a1, a2;
		start();
		byteOut({ADDR, 1'b0}, a0);
		byteOut(p, a1);
		byteOut(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask

	// pointer set, then repeated start into a one-byte read
	task automatic readReg(input logic [7:0] p, output logic [7:0] d,
		output logic ok);
		logic a0, a1, a2;
		start();
		byteOut({ADDR, 1'b0}, a0);
		byteOut(p, a1);
		start();
		byteOut({ADDR, 1'b1}, a2);
		byteIn(d, 1'b1);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule

// ===== touch_sense_config_tb_top.sv
// self-checking bench for the touch-sense configuration bank
// assumes the host model file and the design files are compiled first
`timescale 1ns/1ps
`include "touch_sense_defines.svh"
module touch_sense_config_tb_top;
	localparam logic [6:0] ADDR = 7'h2C; // arbitrary bus address
	localparam int         MS   = 10;    // shortened millisecond
	logic        sys_clk, reset_n, sdaOut, sdaOe, scl, sdaLow, sdaLine;
	logic [2:0]  sampleValid, lowFreqNoise, touched, recalUse, recalRestart;
	logic [47:0] rawDelta, rawBase;
	logic [23:0] noiseThreshold, touchThreshold, deltaCount, baseShown;
	logic [3:0]  holdLimitCode;
	logic [6:0]  cfg2Bits; // second config levels, bit 1 of reg skipped
	int          errorCnt, nCompared, n;
	logic [7:0]  e;
	logic        seen;

	// open drain wire with pull-up
	assign sdaLine = !(sdaLow || (sdaOe && !sdaOut));

	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	touch_host_model #(.ADDR(ADDR)) host (.sys_clk(sys_clk),
		.sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));

	// short counts keep timeouts and hold limits inside the run
	touch_sense_config #(.SLAVE_ADDR(ADDR), .LOW_CYCLES(200),
		.IDLE_CYCLES(100), .MS_CYCLES(MS)) uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .sclIn(scl),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.sampleValid(sampleValid), .rawDelta(rawDelta), .rawBase(rawBase),
		.lowFreqNoise(lowFreqNoise), .noiseThreshold(noiseThreshold),
		.touchThreshold(touchThreshold), .holdLimitCode(holdLimitCode),
		.deltaCount(deltaCount), .baseShown(baseShown), .touched(touched),
		.recalUse(recalUse), .recalRestart(recalRestart),
		.linkedTransitionInvert(cfg2Bits[6]),
		.alertPinPolarity(cfg2Bits[5]), .sensorPowerdownBlock(cfg2Bits[4]),
		.polarityMirrorUnlink(cfg2Bits[3]),
		.radioNoiseOnlyFlags(cfg2Bits[2]),
		.radioNoiseFilterOff(cfg2Bits[1]),
		.releaseIrqSuppress(cfg2Bits[0]));

	task automatic chk(input string what, input logic [23:0] exp, got);
		nCompared++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] p, d);
		logic ok;
		host.writeReg(p, d, ok);
		chk("write ack", 24'h1, 24'(ok));
	endtask

	task automatic rd(input logic [7:0] p, exp);
		logic [7:0] d;
		logic       ok;
		host.readReg(p, d, ok);
		chk("read ack", 24'h1, 24'(ok));
		chk("read data", 24'(exp), 24'(d));
	endtask

	// one strobe on all channels; returns when outputs have landed
	task automatic samp(input logic [47:0] d, input logic [2:0] lf);
		@(posedge sys_clk);
		#1;
		rawDelta     = d;
		lowFreqNoise = lf;
		sampleValid  = 3'b111;
		@(posedge sys_clk);
		#1;
		sampleValid = 3'b000;
	endtask

	// gain as arithmetic shift, clipped to the signed byte
	function automatic logic [7:0] expDelta(input logic [15:0] r, int g);
		int s;
		s = int'($signed(r)) >>> g;
		return (s > 127) ? 8'h7F : (s < -128) ? 8'h80 : 8'(s);
	endfunction

	function automatic logic [7:0] expBase(input logic [15:0] r, int sh);
		int s;
		s = int'(r) >> ((sh > 8) ? 8 : sh);
		return (s > 255) ? 8'hFF : 8'(s);
	endfunction

	// stretch the ack slot low well past the shortened limit
	task automatic lowHold(input logic [7:0] cfg, input logic expOe);
		logic b;
		wr(8'h20, cfg);
		host.start();
		host.sendBits({ADDR, 1'b0});
		repeat (300) @(posedge sys_clk);
		#1;
		chk("ack after long low", 24'(expOe), 24'(sdaOe));
		host.recvBit(b);
		if (expOe) begin
			host.byteOut(8'h00, b);
		end
		host.stop();
	endtask

	// idle-high bus inside a pointer byte; a reset port no longer acks
	task automatic idleHold(input logic [7:0] cfg, input logic expAck);
		logic b;
		wr(8'h20, cfg);
		host.start();
		host.sendBits({ADDR, 1'b0});
		host.recvBit(b);
		host.pause(150);
		repeat (7) host.sendBit(1'b0);
		host.recvBit(b);
		chk("ack after long high", 24'(expAck), 24'(!b));
		host.stop();
	endtask

	task automatic give_verdict();
		if (errorCnt == 0 && nCompared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// watchdog: the run needs well under half of this
	initial begin
		repeat (100000) @(posedge sys_clk);
		errorCnt++;
		give_verdict();
	end

	initial begin
		void'($urandom(73));
		reset_n = 1'b0;
		sampleValid = 3'b000;
		lowFreqNoise = 3'b000;
		rawDelta = 48'h0;
		rawBase = 48'h0;
		noiseThreshold = {3{8'h08}};
		touchThreshold = {3{8'h40}};
		holdLimitCode = 4'h0;
		repeat (16) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		// reset values, then unused bits dropped
		chk("cfg2 levels", 24'h20, 24'(cfg2Bits));
		rd(8'h1F, 8'h20);
		rd(8'h20, 8'h20);
		rd(8'h44, 8'h40);
		rd(8'h00, 8'h00);
		wr(8'h1F, 8'hFF);
		rd(8'h1F, 8'h7F);
		wr(8'h20, 8'hFF);
		rd(8'h20, 8'hB8);
		wr(8'h44, 8'hFF);
		rd(8'h44, 8'hFD);
		chk("cfg2 levels", 24'h7F, 24'(cfg2Bits));
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h00);
		wr(8'h20, 8'h00);
		// every gain code, random base scale, clipping corners
		for (int g = 0; g < 8; g++) begin
			n = (g == 7) ? 8 : $urandom_range(15);
			wr(8'h1F, {1'b0, 3'(g), 4'(n)});
			rawBase = {16'($urandom), 16'($urandom), 16'($urandom)};
			// code zero: a delta of 64 shows as 40h, the top magnitude bit
			samp({16'h8000, 16'h7FFF, (g == 0) ? 16'h0040 : 16'($urandom)},
				3'b000);
			for (int c = 0; c < 3; c++) begin
				e = expDelta(rawDelta[16*c+:16], g);
				chk("delta", 24'(e), 24'(deltaCount[8*c+:8]));
				chk("base", 24'(expBase(rawBase[16*c+:16], n)),
					24'(baseShown[8*c+:8]));
				chk("touch", 24'($signed(e) > 8'sh40),
					24'(touched[c]));
			end
		end
		// noise gate on, low-frequency filter on
		wr(8'h1F, 8'h00);
		samp({3{16'h0020}}, 3'b001);
		chk("delta noise", 24'h202000, deltaCount);
		chk("recal in band", 24'h0, 24'(recalUse));
		samp({3{16'h0004}}, 3'b000);
		chk("recal quiet", 24'h7, 24'(recalUse));
		// both filters off
		wr(8'h20, 8'h30);
		samp({3{16'h0020}}, 3'b111);
		chk("delta unfiltered", 24'h202020, deltaCount);
		chk("recal gate off", 24'h7, 24'(recalUse));
		// held touch with hold recalibration on, shortest limit
		wr(8'h20, 8'h08);
		samp({3{16'h0050}}, 3'b000);
		chk("held touch", 24'h7, 24'(touched));
		n = 0;
		while (recalRestart[0] !== 1'b1 && n < 7000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		// tick phase is free running, so allow a couple of ticks
		chk("hold time", 24'h1, 24'(n >= int'(`HOLD_MS_0) * MS - 30
			&& n <= int'(`HOLD_MS_0) * MS + 30));
		wr(8'h20, 8'h00);
		seen = 1'b0;
		repeat (6000) begin
			@(posedge sys_clk);
			#1;
			seen = seen | recalRestart[0];
		end
		chk("no hold restart", 24'h0, 24'(seen));
		// held-low clock with and without the timeout
		lowHold(8'h80, 1'b0);
		lowHold(8'h00, 1'b1);
		// idle-high lines with and without the timeout
		idleHold(8'h80, 1'b0);
		idleHold(8'h00, 1'b1);
		give_verdict();
	end
endmodule
